// [verilog/arv_vblank_ctrl.sv]
// adaptive refresh vblank control: apb registers, line counter and termination machine
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module arv_vblank_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timing to pipe and panel
  output logic panel_vblank,
  output logic delayed_vblank,
  output logic db_update,
  output logic frame_start,
  output logic [15:0] line_count,
  output logic adaptive_live,
  // interrupt
  output logic irq
);
  localparam int LW = arv_pkg::LW;

  // settings
  logic vrr_enable;
  logic flip_enable;
  logic push_enable;
  logic send_push;
  logic [LW-1:0] guardband;
  logic [LW-1:0] w2_lines;
  logic [LW-1:0] vtotal;
  logic [LW-1:0] vmax;
  logic [LW-1:0] vmin;
  logic [LW-1:0] flipline;
  logic [LW-1:0] htotal;
  logic [LW-1:0] vactive;
  logic [arv_pkg::IRQ_W-1:0] int_status;
  logic [arv_pkg::IRQ_W-1:0] int_mask;

  // timing state
  arv_pkg::arv_state_t state;
  logic [LW-1:0] line_cnt;
  logic [LW-1:0] phase_cnt;
  logic [LW-1:0] prev_total;
  logic line_tick;

  // apb decode
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_word;
  logic [arv_pkg::IRQ_W-1:0] rd_clear;

  // termination terms
  logic [LW-1:0] next_line;
  logic [LW-1:0] ph1;
  logic [LW:0] overhead;
  logic [LW-1:0] min_limit;
  logic [LW-1:0] min_bnd;
  logic [LW-1:0] max_bnd;
  logic [LW-1:0] nom_bnd;
  logic push_due;
  logic max_due;
  logic nom_due;
  logic term_due;
  logic enter_fill;
  logic end_frame;
  logic fs_hit;
  logic [arv_pkg::IRQ_W-1:0] events;

  // boundary = limit - guardband - latency window, floored at zero
  function automatic logic [15:0] bound_of(input logic [15:0] lim, input logic [16:0] ovh);
    logic [16:0] diff;
    diff = {1'b0, lim} - ovh;
    if ({1'b0, lim} > ovh) begin
      bound_of = diff[15:0];
    end else begin
      bound_of = '0;
    end
  endfunction

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_word = '0;
    unique case (paddr)
      arv_pkg::ADDR_CTRL: begin
        rd_word[arv_pkg::CTRL_EN_BIT] = vrr_enable;
        rd_word[arv_pkg::CTRL_FLIP_BIT] = flip_enable;
        rd_word[arv_pkg::CTRL_GB_LSB +: LW] = guardband;
      end
      arv_pkg::ADDR_W2: rd_word[LW-1:0] = w2_lines;
      arv_pkg::ADDR_VTOTAL: rd_word[LW-1:0] = vtotal;
      arv_pkg::ADDR_VMAX: rd_word[LW-1:0] = vmax;
      arv_pkg::ADDR_VMIN: rd_word[LW-1:0] = vmin;
      arv_pkg::ADDR_FLIPLINE: rd_word[LW-1:0] = flipline;
      arv_pkg::ADDR_PUSH: begin
        rd_word[arv_pkg::PUSH_SEND_BIT] = send_push;
        rd_word[arv_pkg::PUSH_EN_BIT] = push_enable;
      end
      arv_pkg::ADDR_STATUS: begin
        rd_word[arv_pkg::STAT_LIVE_BIT] = adaptive_live;
        rd_word[arv_pkg::STAT_PVB_BIT] = panel_vblank;
        rd_word[arv_pkg::STAT_DVB_BIT] = delayed_vblank;
        rd_word[arv_pkg::STAT_STATE_LSB +: 2] = state;
        rd_word[arv_pkg::STAT_LINE_LSB +: LW] = line_cnt;
      end
      arv_pkg::ADDR_INT_STAT: rd_word[arv_pkg::IRQ_W-1:0] = int_status;
      arv_pkg::ADDR_INT_MASK: rd_word[arv_pkg::IRQ_W-1:0] = int_mask;
      arv_pkg::ADDR_HTOTAL: rd_word[LW-1:0] = htotal;
      arv_pkg::ADDR_VACTIVE: rd_word[LW-1:0] = vactive;
      arv_pkg::ADDR_PREV_TOTAL: rd_word[LW-1:0] = prev_total;
      default: mapped = 1'b0;
    endcase
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= ~mapped;
    end
  end

  // only the bits actually returned are cleared, so a later event survives
  assign rd_clear = (rd && paddr == arv_pkg::ADDR_INT_STAT) ? prdata[arv_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vrr_enable <= 1'b0;
      flip_enable <= 1'b0;
      guardband <= arv_pkg::RST_GUARDBAND;
      w2_lines <= arv_pkg::RST_W2;
      vtotal <= arv_pkg::RST_VTOTAL;
      vmax <= arv_pkg::RST_VMAX;
      vmin <= arv_pkg::RST_VMIN;
      flipline <= arv_pkg::RST_FLIPLINE;
      htotal <= arv_pkg::RST_HTOTAL;
      vactive <= arv_pkg::RST_VACTIVE;
      int_mask <= arv_pkg::RST_INT_MASK;
      push_enable <= 1'b0;
    end else if (wr) begin
      unique case (paddr)
        arv_pkg::ADDR_CTRL: begin
          vrr_enable <= pwdata[arv_pkg::CTRL_EN_BIT];
          flip_enable <= pwdata[arv_pkg::CTRL_FLIP_BIT];
          guardband <= pwdata[arv_pkg::CTRL_GB_LSB +: LW];
        end
        arv_pkg::ADDR_W2: w2_lines <= pwdata[LW-1:0];
        arv_pkg::ADDR_VTOTAL: vtotal <= pwdata[LW-1:0];
        arv_pkg::ADDR_VMAX: vmax <= pwdata[LW-1:0];
        arv_pkg::ADDR_VMIN: vmin <= pwdata[LW-1:0];
        arv_pkg::ADDR_FLIPLINE: flipline <= pwdata[LW-1:0];
        arv_pkg::ADDR_PUSH: push_enable <= pwdata[arv_pkg::PUSH_EN_BIT];
        arv_pkg::ADDR_INT_MASK: int_mask <= pwdata[arv_pkg::IRQ_W-1:0];
        arv_pkg::ADDR_HTOTAL: htotal <= pwdata[LW-1:0];
        arv_pkg::ADDR_VACTIVE: vactive <= pwdata[LW-1:0];
        default: ;
      endcase
    end
  end

  // request bit: write 1 sets, buffer update clears, a set in that same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_push <= 1'b0;
    end else if (wr && paddr == arv_pkg::ADDR_PUSH && pwdata[arv_pkg::PUSH_SEND_BIT]) begin
      send_push <= 1'b1;
    end else if (enter_fill) begin
      send_push <= 1'b0;
    end
  end

  arv_line_timer #(
    .W(LW)
  ) u_line_timer (
    .pclk(pclk),
    .presetn(presetn),
    .period(htotal),
    .line_tick(line_tick)
  );

  assign next_line = line_cnt + 1'b1;
  assign ph1 = phase_cnt + 1'b1;
  assign overhead = {1'b0, guardband} + {1'b0, w2_lines};
  // flip line never pulls the frame below the minimum total
  assign min_limit = (flip_enable && flipline > vmin) ? flipline : vmin;
  // flip line is read live, so it must be written before the request
  assign min_bnd = bound_of(min_limit, overhead);
  assign max_bnd = bound_of(vmax, overhead);
  assign nom_bnd = bound_of(vtotal, overhead);

  // one compare covers both early (wait) and late (immediate) requests
  assign push_due = adaptive_live & push_enable & send_push & (next_line >= min_bnd);
  assign max_due = adaptive_live & (next_line >= max_bnd);
  assign nom_due = ~adaptive_live & (next_line >= nom_bnd);
  assign term_due = push_due | max_due | nom_due;

  assign enter_fill = line_tick & (((state == arv_pkg::ST_STRETCH) & term_due & (w2_lines == '0)) |
                                   ((state == arv_pkg::ST_LATENCY) & (ph1 >= w2_lines)));
  // a zero guardband still gives one fill line; software keeps it larger
  assign end_frame = line_tick & (state == arv_pkg::ST_FILL) & (ph1 >= guardband);
  assign fs_hit = line_tick & (state == arv_pkg::ST_FILL) & (ph1 == arv_pkg::FS_DELAY_LINES);

  // line counter restarts each frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= arv_pkg::ST_ACTIVE;
      line_cnt <= '0;
      phase_cnt <= '0;
    end else if (line_tick) begin
      line_cnt <= next_line;
      unique case (state)
        arv_pkg::ST_ACTIVE: begin
          if (next_line >= vactive) begin
            state <= arv_pkg::ST_STRETCH;
          end
        end
        arv_pkg::ST_STRETCH: begin
          if (term_due) begin
            phase_cnt <= '0;
            state <= (w2_lines == '0) ? arv_pkg::ST_FILL : arv_pkg::ST_LATENCY;
          end
        end
        arv_pkg::ST_LATENCY: begin
          if (ph1 >= w2_lines) begin
            phase_cnt <= '0;
            state <= arv_pkg::ST_FILL;
          end else begin
            phase_cnt <= ph1;
          end
        end
        arv_pkg::ST_FILL: begin
          if (ph1 >= guardband) begin
            phase_cnt <= '0;
            line_cnt <= '0;
            state <= arv_pkg::ST_ACTIVE;
          end else begin
            phase_cnt <= ph1;
          end
        end
      endcase
    end
  end

  // panel-side and pipe-side blanking levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_vblank <= 1'b0;
    end else if (end_frame) begin
      panel_vblank <= 1'b0;
    end else if (line_tick && state == arv_pkg::ST_ACTIVE && next_line >= vactive) begin
      panel_vblank <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delayed_vblank <= 1'b0;
    end else if (end_frame) begin
      delayed_vblank <= 1'b0;
    end else if (enter_fill) begin
      delayed_vblank <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_update <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      db_update <= enter_fill;
      frame_start <= fs_hit;
    end
  end

  // live status only follows the enable at a frame boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adaptive_live <= 1'b0;
      prev_total <= '0;
    end else if (end_frame) begin
      adaptive_live <= vrr_enable;
      prev_total <= next_line;
    end
  end

  assign line_count = line_cnt;

  // interrupt events
  always_comb begin
    events = '0;
    events[arv_pkg::IRQ_DB] = enter_fill;
    events[arv_pkg::IRQ_FS] = fs_hit;
    events[arv_pkg::IRQ_MAX] = line_tick & (state == arv_pkg::ST_STRETCH) & max_due & ~push_due;
    events[arv_pkg::IRQ_LIVE] = end_frame & (adaptive_live != vrr_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~rd_clear) | events;
    end
  end

  assign irq = |(int_status & int_mask);
endmodule

// [inc/arv_pkg.sv]
// constants, register map and state type for the adaptive refresh vblank control
package arv_pkg;
  localparam int LW = 16;
  localparam int AW = 12;
  localparam int IRQ_W = 4;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_W2 = 12'h004;
  localparam logic [11:0] ADDR_VTOTAL = 12'h008;
  localparam logic [11:0] ADDR_VMAX = 12'h00c;
  localparam logic [11:0] ADDR_VMIN = 12'h010;
  localparam logic [11:0] ADDR_FLIPLINE = 12'h014;
  localparam logic [11:0] ADDR_PUSH = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01c;
  localparam logic [11:0] ADDR_INT_STAT = 12'h020;
  localparam logic [11:0] ADDR_INT_MASK = 12'h024;
  localparam logic [11:0] ADDR_HTOTAL = 12'h028;
  localparam logic [11:0] ADDR_VACTIVE = 12'h02c;
  localparam logic [11:0] ADDR_PREV_TOTAL = 12'h030;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FLIP_BIT = 1;
  localparam int CTRL_GB_LSB = 16;
  localparam int PUSH_SEND_BIT = 0;
  localparam int PUSH_EN_BIT = 1;
  localparam int STAT_LIVE_BIT = 0;
  localparam int STAT_PVB_BIT = 1;
  localparam int STAT_DVB_BIT = 2;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_LINE_LSB = 16;
  localparam int IRQ_DB = 0;
  localparam int IRQ_FS = 1;
  localparam int IRQ_MAX = 2;
  localparam int IRQ_LIVE = 3;

  // values after reset
  localparam logic [15:0] RST_GUARDBAND = 16'h0008;
  localparam logic [15:0] RST_W2 = 16'h0002;
  localparam logic [15:0] RST_VTOTAL = 16'h0040;
  localparam logic [15:0] RST_VMAX = 16'h0060;
  localparam logic [15:0] RST_VMIN = 16'h0040;
  localparam logic [15:0] RST_FLIPLINE = 16'h0040;
  localparam logic [15:0] RST_HTOTAL = 16'h0010;
  localparam logic [15:0] RST_VACTIVE = 16'h0020;
  localparam logic [3:0] RST_INT_MASK = 4'h0;

  // lines from double-buffer update to frame start
  localparam logic [15:0] FS_DELAY_LINES = 16'h0001;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_STRETCH,
    ST_LATENCY,
    ST_FILL
  } arv_state_t;
endpackage

// [verilog/arv_line_timer.sv]
// scanline timer: one pulse per line period of pclk cycles
`timescale 1ns/10ps
module arv_line_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line length in clocks
  input wire logic [W-1:0] period,
  // one-cycle pulse on the clock after the last clock of each line
  output logic line_tick
);
  logic [W-1:0] cnt;
  logic last;

  // a period of zero or one still gives one tick per clock
  assign last = ({1'b0, cnt} + 1'b1) >= {1'b0, period};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tick <= 1'b0;
    end else begin
      line_tick <= last;
    end
  end
endmodule

// [verification/arv_vblank_ctrl_monitor.sv]
// concurrent checks on the vblank control ports
`timescale 1ns/10ps
module arv_vblank_ctrl_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb answer
  input wire logic pready,
  // timing
  input wire logic panel_vblank,
  input wire logic delayed_vblank,
  input wire logic db_update,
  input wire logic frame_start,
  input wire logic [15:0] line_count,
  input wire logic adaptive_live
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_update;
    $rose(delayed_vblank) ##0 db_update;
  endsequence
  sequence s_pulse_gone;
    ##1 !db_update;
  endsequence

  a_update_one_cycle: assert property (db_update |-> s_pulse_gone) else $error("update pulse too long");
  a_update_opens_dvb: assert property ($rose(delayed_vblank) |-> db_update) else $error("delayed vblank without update");
  a_fs_after_update: assert property (s_update |-> !frame_start) else $error("frame start with update");
  a_dvb_in_pvb: assert property (delayed_vblank |-> panel_vblank) else $error("delayed vblank outside vblank");
  a_fs_in_dvb: assert property (frame_start |-> delayed_vblank && !db_update) else $error("frame start misplaced");
  a_frame_end: assert property ($fell(delayed_vblank) |-> line_count == 16'h0000 && !panel_vblank)
    else $error("frame end misaligned");
  a_live_at_end: assert property ($changed(adaptive_live) |-> line_count == 16'h0000)
    else $error("live status changed mid-frame");
  a_line_steps: assert property ($changed(line_count) |-> line_count == $past(line_count) + 16'h0001 ||
    line_count == 16'h0000) else $error("line counter jumped");
  a_ready_high: assert property (pready) else $error("apb ready low");
endmodule

bind arv_vblank_ctrl arv_vblank_ctrl_monitor u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .pready(pready),
  .panel_vblank(panel_vblank),
  .delayed_vblank(delayed_vblank),
  .db_update(db_update),
  .frame_start(frame_start),
  .line_count(line_count),
  .adaptive_live(adaptive_live)
);

// [verification/arv_pipe_model.sv]
// pipe side model: takes updates at delayed vblank and records frame lengths
`timescale 1ns/10ps
module arv_pipe_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timing from the block
  input wire logic delayed_vblank,
  input wire logic db_update,
  input wire logic frame_start,
  input wire logic [15:0] line_count,
  // observations
  output logic [15:0] total,
  output logic [15:0] db_line,
  output logic [15:0] fs_line,
  output logic [7:0] frames
);
  logic dvb_q;
  logic [15:0] last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dvb_q <= 1'b0;
      last <= 16'h0000;
      total <= 16'h0000;
      db_line <= 16'h0000;
      fs_line <= 16'h0000;
      frames <= 8'h00;
    end else begin
      dvb_q <= delayed_vblank;
      if (line_count != 16'h0000) last <= line_count;
      // frame closes when delayed vblank drops
      if (dvb_q && !delayed_vblank) begin
        total <= last + 16'h0001;
        frames <= frames + 8'h01;
      end
      // pipe registers latch here
      if (db_update) db_line <= line_count;
      if (frame_start) fs_line <= line_count;
    end
  end
endmodule

// [verification/adaptive_refresh_vblank_control_bench.sv]
// self-checking bench for the adaptive refresh vblank control
`timescale 1ns/10ps
module adaptive_refresh_vblank_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, panel_vblank, delayed_vblank, db_update, frame_start, adaptive_live, irq;
  logic [15:0] line_count, total, db_line, fs_line;
  logic [7:0] frames;
  logic [31:0] rdat;
  logic lerr;
  int failures = 0;
  int cmp_count = 0;

  always #10 pclk = ~pclk;

  arv_vblank_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_vblank(panel_vblank), .delayed_vblank(delayed_vblank), .db_update(db_update),
    .frame_start(frame_start), .line_count(line_count), .adaptive_live(adaptive_live), .irq(irq));
  arv_pipe_model u_pipe (.pclk(pclk), .presetn(presetn), .delayed_vblank(delayed_vblank),
    .db_update(db_update), .frame_start(frame_start), .line_count(line_count), .total(total),
    .db_line(db_line), .fs_line(fs_line), .frames(frames));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  // called just after a rising edge; ends one edge after release so back-to-back calls never collide
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      close_out();
    end
    @(posedge pclk);
  endtask

  task automatic wait_frame();
    int n;
    logic [7:0] f;
    f = frames;
    for (n = 0; n < 3000 && frames === f; n++) @(posedge pclk);
    if (frames === f) begin
      failures++;
      close_out();
    end
  endtask

  task automatic wait_line(input logic [15:0] l);
    int n;
    for (n = 0; n < 3000 && line_count !== l; n++) @(posedge pclk);
    if (line_count !== l) begin
      failures++;
      close_out();
    end
  endtask

  task automatic t_reset_vals();
    apb(arv_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0008_0000);
    apb(arv_pkg::ADDR_VMAX, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_0060);
    apb(12'h0fc, 1'b0, 32'h0000_0000);
    chk({31'h0, lerr}, 32'h0000_0001);
    // minimum total keeps vblank well above the guardband
    apb(arv_pkg::ADDR_VMIN, 1'b1, 32'h0000_0040);
    apb(arv_pkg::ADDR_HTOTAL, 1'b1, 32'h0000_0004);
  endtask

  task automatic t_nominal();
    wait_frame();
    wait_frame();
    chk(total, 32'h0000_0040);
    chk(db_line, 32'h0000_0038);
    chk(fs_line, 32'h0000_0039);
    apb(arv_pkg::ADDR_PREV_TOTAL, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_0040);
  endtask

  task automatic t_max_irq();
    apb(arv_pkg::ADDR_CTRL, 1'b1, 32'h0008_0003);
    apb(arv_pkg::ADDR_PUSH, 1'b1, 32'h0000_0002);
    wait_frame();
    chk({31'h0, adaptive_live}, 32'h0000_0001);
    wait_frame();
    chk(total, 32'h0000_0060);
    apb(arv_pkg::ADDR_INT_MASK, 1'b1, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(arv_pkg::ADDR_INT_STAT, 1'b0, 32'h0000_0000);
    chk(rdat & 32'h0000_0004, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(arv_pkg::ADDR_INT_MASK, 1'b1, 32'h0000_0000);
  endtask

  task automatic t_early_push();
    wait_frame();
    apb(arv_pkg::ADDR_FLIPLINE, 1'b1, 32'h0000_0050);
    apb(arv_pkg::ADDR_PUSH, 1'b1, 32'h0000_0003);
    wait_frame();
    chk(total, 32'h0000_0050);
    chk(db_line, 32'h0000_0048);
    apb(arv_pkg::ADDR_PUSH, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_0002);
  endtask

  task automatic t_late_push();
    apb(arv_pkg::ADDR_FLIPLINE, 1'b1, 32'h0000_0040);
    wait_line(16'h0046);
    apb(arv_pkg::ADDR_PUSH, 1'b1, 32'h0000_0003);
    wait_frame();
    // request lands on line 70 or 71, termination is immediate
    chk({31'h0, total >= 16'h0050 && total <= 16'h0052}, 32'h0000_0001);
  endtask

  task automatic t_held_push();
    int n;
    for (n = 0; n < 3000 && db_update !== 1'b1; n++) @(posedge pclk);
    if (db_update !== 1'b1) begin
      failures++;
      close_out();
    end
    @(posedge pclk);
    apb(arv_pkg::ADDR_PUSH, 1'b1, 32'h0000_0003);
    apb(arv_pkg::ADDR_PUSH, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_0003);
    wait_frame();
    chk(total, 32'h0000_0060);
    wait_frame();
    chk(total, 32'h0000_0040);
  endtask

  task automatic t_flip_off();
    apb(arv_pkg::ADDR_CTRL, 1'b1, 32'h0008_0001);
    apb(arv_pkg::ADDR_FLIPLINE, 1'b1, 32'h0000_0050);
    apb(arv_pkg::ADDR_INT_STAT, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_0007);
    apb(arv_pkg::ADDR_PUSH, 1'b1, 32'h0000_0003);
    wait_frame();
    // flip line disabled: the request ends the frame at the minimum total
    chk(total, 32'h0000_0040);
    apb(arv_pkg::ADDR_INT_STAT, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_0003);
  endtask

  task automatic t_disable();
    apb(arv_pkg::ADDR_CTRL, 1'b1, 32'h0008_0000);
    chk({31'h0, adaptive_live}, 32'h0000_0001);
    wait_frame();
    chk({31'h0, adaptive_live}, 32'h0000_0000);
    apb(arv_pkg::ADDR_INT_STAT, 1'b0, 32'h0000_0000);
    chk(rdat, 32'h0000_000f);
    wait_frame();
    chk(total, 32'h0000_0040);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_vals();
    t_nominal();
    t_max_irq();
    t_early_push();
    t_late_push();
    t_held_push();
    t_flip_off();
    t_disable();
    close_out();
  end
endmodule
